// file: design/timer_irq_flag_bank.sv
// timer_irq_flag_bank: flags, masks and vector requests for two 16-bit timers
// assumes: byte register port, vector acknowledge from the core, timer ticks
`timescale 1ns/10ps
module timer_irq_flag_bank
  import timer_irq_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // register port
  input  wire logic [7:0]       regAddr,
  input  wire logic             regWrite,
  input  wire logic [7:0]       regWdata,
  output logic      [7:0]       regRdata,
  input  wire logic             globalIrqEnable,
  // vector handshake
  output logic                  irqRequest,
  output logic      [3:0]       irqVector,
  input  wire logic             vectorTaken,
  input  wire logic [3:0]       vectorTakenId,
  // timer1
  input  wire logic             t1Tick,
  input  wire logic [WIDTH-1:0] t1_counter,
  input  wire logic [WIDTH-1:0] t1_cmp_a_value,
  input  wire logic [WIDTH-1:0] t1_cmp_b_value,
  input  wire logic [WIDTH-1:0] t1_cmp_c_value,
  input  wire logic [WIDTH-1:0] t1_capture_value,
  input  wire logic [3:0]       wave_mode_sel,
  input  wire logic             t1OverflowStrobe,
  input  wire logic             t1CaptureEvent,
  // timer3
  input  wire logic             t3Tick,
  input  wire logic [WIDTH-1:0] t3_counter,
  input  wire logic [WIDTH-1:0] t3_cmp_a_value,
  input  wire logic [WIDTH-1:0] t3_cmp_b_value,
  input  wire logic [WIDTH-1:0] t3_cmp_c_value,
  input  wire logic [WIDTH-1:0] t3_capture_value,
  input  wire logic [3:0]       t3_wave_mode_sel,
  input  wire logic             t3OverflowStrobe,
  input  wire logic             t3CapturePinEvent
);
  import timer_irq_pkg::*;

  // ******************************
  // event detection
  // ******************************
  logic t1SetA;
  logic t1SetB;
  logic t1SetC;
  logic t1SetOvf;
  logic t1SetCap;
  logic t3SetA;
  logic t3SetB;
  logic t3SetC;
  logic t3SetOvf;
  logic t3SetCap;

  timer_event_detect #(.WIDTH(WIDTH)) t1Detect (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .timerTick      (t1Tick),
    .counter        (t1_counter),
    .cmpA           (t1_cmp_a_value),
    .cmpB           (t1_cmp_b_value),
    .cmpC           (t1_cmp_c_value),
    .captureValue   (t1_capture_value),
    .waveModeSel    (wave_mode_sel),
    .overflowStrobe (t1OverflowStrobe),
    .captureEvent   (t1CaptureEvent),
    .setA           (t1SetA),
    .setB           (t1SetB),
    .setC           (t1SetC),
    .setOvf         (t1SetOvf),
    .setCap         (t1SetCap)
  );

  timer_event_detect #(.WIDTH(WIDTH)) t3Detect (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .timerTick      (t3Tick),
    .counter        (t3_counter),
    .cmpA           (t3_cmp_a_value),
    .cmpB           (t3_cmp_b_value),
    .cmpC           (t3_cmp_c_value),
    .captureValue   (t3_capture_value),
    .waveModeSel    (t3_wave_mode_sel),
    .overflowStrobe (t3OverflowStrobe),
    .captureEvent   (t3CapturePinEvent),
    .setA           (t3SetA),
    .setB           (t3SetB),
    .setC           (t3SetC),
    .setOvf         (t3SetOvf),
    .setCap         (t3SetCap)
  );

  // ******************************
  // flag and mask registers
  // ******************************
  logic [7:0] shared_timer_event_flags;
  logic [7:0] extended_timer_event_flags;
  logic [7:0] shared_timer_irq_mask;
  logic [7:0] extended_timer_irq_mask;
  logic [7:0] next_sharedFlags;
  logic [7:0] next_extFlags;
  logic [7:0] next_sharedMask;
  logic [7:0] next_extMask;
  logic [7:0] sharedSet;
  logic [7:0] extSet;
  logic [7:0] sharedAck;
  logic [7:0] extAck;
  logic [7:0] sharedW1c;
  logic [7:0] extW1c;

  // set vectors placed at their bit positions
  always_comb
  begin
    sharedSet        = 8'h00;
    sharedSet[S_CAP] = t1SetCap;
    sharedSet[S_A]   = t1SetA;
    sharedSet[S_B]   = t1SetB;
    sharedSet[S_OVF] = t1SetOvf;
    extSet           = 8'h00;
    extSet[E_CAP]    = t3SetCap;
    extSet[E_A]      = t3SetA;
    extSet[E_B]      = t3SetB;
    extSet[E_OVF]    = t3SetOvf;
    extSet[E_C3]     = t3SetC;
    extSet[E_C1]     = t1SetC;
  end

  // clear of the flag whose vector is being taken
  always_comb
  begin
    sharedAck = 8'h00;
    extAck    = 8'h00;
    if (vectorTaken)
    begin
      case (vec_t'(vectorTakenId))
        VEC_T1_CAP: sharedAck[S_CAP] = 1'b1;
        VEC_T1_A:   sharedAck[S_A]   = 1'b1;
        VEC_T1_B:   sharedAck[S_B]   = 1'b1;
        VEC_T1_OVF: sharedAck[S_OVF] = 1'b1;
        VEC_T1_C:   extAck[E_C1]     = 1'b1;
        VEC_T3_CAP: extAck[E_CAP]    = 1'b1;
        VEC_T3_A:   extAck[E_A]      = 1'b1;
        VEC_T3_B:   extAck[E_B]      = 1'b1;
        VEC_T3_C:   extAck[E_C3]     = 1'b1;
        VEC_T3_OVF: extAck[E_OVF]    = 1'b1;
        default:    sharedAck        = 8'h00;
      endcase
    end
  end

  // write-one clears, zero bits leave flags untouched
  assign sharedW1c = (regWrite && regAddr == SHARED_FLAGS_ADDR) ? regWdata : 8'h00;
  assign extW1c    = (regWrite && regAddr == EXT_FLAGS_ADDR) ? regWdata : 8'h00;

  // set beats any clear in the same cycle; unused bits stay zero
  always_comb
  begin
    next_sharedFlags = (shared_timer_event_flags & ~(sharedW1c | sharedAck) | sharedSet)
                       & SHARED_USED;
    next_extFlags    = (extended_timer_event_flags & ~(extW1c | extAck) | extSet)
                       & EXT_USED;
    next_sharedMask  = shared_timer_irq_mask;
    next_extMask     = extended_timer_irq_mask;
    if (regWrite && regAddr == SHARED_MASK_ADDR)
    begin
      next_sharedMask = regWdata & SHARED_USED;
    end
    else if (regWrite && regAddr == EXT_MASK_ADDR)
    begin
      next_extMask = regWdata & EXT_USED;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      shared_timer_event_flags   <= FLAGS_RESET;
      extended_timer_event_flags <= FLAGS_RESET;
      shared_timer_irq_mask      <= MASK_RESET;
      extended_timer_irq_mask    <= MASK_RESET;
    end
    else
    begin
      shared_timer_event_flags   <= next_sharedFlags;
      extended_timer_event_flags <= next_extFlags;
      shared_timer_irq_mask      <= next_sharedMask;
      extended_timer_irq_mask    <= next_extMask;
    end
  end

  // ******************************
  // register read
  // ******************************
  always_comb
  begin
    if (regAddr == SHARED_FLAGS_ADDR)
    begin
      regRdata = shared_timer_event_flags;
    end
    else if (regAddr == EXT_FLAGS_ADDR)
    begin
      regRdata = extended_timer_event_flags;
    end
    else if (regAddr == SHARED_MASK_ADDR)
    begin
      regRdata = shared_timer_irq_mask;
    end
    else if (regAddr == EXT_MASK_ADDR)
    begin
      regRdata = extended_timer_irq_mask;
    end
    else
    begin
      regRdata = 8'h00;
    end
  end

  // ******************************
  // vector request, fixed priority
  // ******************************
  logic [7:0] sharedPend;
  logic [7:0] extPend;

  assign sharedPend = shared_timer_event_flags & shared_timer_irq_mask;
  assign extPend    = extended_timer_event_flags & extended_timer_irq_mask;

  // lowest vector index wins
  always_comb
  begin
    irqRequest = 1'b0;
    irqVector  = VEC_T1_CAP;
    if (globalIrqEnable)
    begin
      irqRequest = 1'b1;
      if (sharedPend[S_CAP])      irqVector = VEC_T1_CAP;
      else if (sharedPend[S_A])   irqVector = VEC_T1_A;
      else if (sharedPend[S_B])   irqVector = VEC_T1_B;
      else if (sharedPend[S_OVF]) irqVector = VEC_T1_OVF;
      else if (extPend[E_C1])     irqVector = VEC_T1_C;
      else if (extPend[E_CAP])    irqVector = VEC_T3_CAP;
      else if (extPend[E_A])      irqVector = VEC_T3_A;
      else if (extPend[E_B])      irqVector = VEC_T3_B;
      else if (extPend[E_C3])     irqVector = VEC_T3_C;
      else if (extPend[E_OVF])    irqVector = VEC_T3_OVF;
      else                        irqRequest = 1'b0;
    end
  end
endmodule : timer_irq_flag_bank

// file: design/timer_irq_pkg.sv
// timer_irq_pkg: register offsets, bit positions, reset values and wave modes
// assumes: byte-wide register port on the processor's data space
package timer_irq_pkg;
  localparam logic [7:0] SHARED_FLAGS_ADDR = 8'h36;
  localparam logic [7:0] SHARED_MASK_ADDR  = 8'h37;
  localparam logic [7:0] EXT_FLAGS_ADDR    = 8'h7C;
  localparam logic [7:0] EXT_MASK_ADDR     = 8'h7D;
  localparam logic [7:0] FLAGS_RESET       = 8'h00;
  localparam logic [7:0] MASK_RESET        = 8'h00;
  // bit positions in the shared register
  localparam int S_CAP = 5;
  localparam int S_A   = 4;
  localparam int S_B   = 3;
  localparam int S_OVF = 2;
  // bit positions in the extended register
  localparam int E_CAP  = 5;
  localparam int E_A    = 4;
  localparam int E_B    = 3;
  localparam int E_OVF  = 2;
  localparam int E_C3   = 1;
  localparam int E_C1   = 0;
  localparam logic [7:0] SHARED_USED = 8'h3C;
  localparam logic [7:0] EXT_USED    = 8'h3F;
  // interrupt vector indices
  typedef enum logic [3:0] {
    VEC_T1_CAP = 4'h0, VEC_T1_A = 4'h1, VEC_T1_B = 4'h2, VEC_T1_OVF = 4'h3,
    VEC_T1_C = 4'h4, VEC_T3_CAP = 4'h5, VEC_T3_A = 4'h6, VEC_T3_B = 4'h7,
    VEC_T3_C = 4'h8, VEC_T3_OVF = 4'h9
  } vec_t;
  localparam int NUM_VEC = 10;
  // wave mode codes of interest
  localparam logic [3:0] MODE_NORMAL    = 4'h0;
  localparam logic [3:0] MODE_CTC_CMP_A = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP   = 4'hC;
  localparam logic [3:0] MODE_PWM_CAP_A = 4'h8;
  localparam logic [3:0] MODE_PWM_CAP_B = 4'hA;
  localparam logic [3:0] MODE_FAST_CAP  = 4'hE;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
endpackage : timer_irq_pkg

// file: design/timer_event_detect.sv
// timer_event_detect: per-timer flag set events from compares and counter
// assumes: counter and compare values are stable in the timer tick cycle
`timescale 1ns/10ps
module timer_event_detect
  import timer_irq_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             timerTick,
  input  wire logic [WIDTH-1:0] counter,
  input  wire logic [WIDTH-1:0] cmpA,
  input  wire logic [WIDTH-1:0] cmpB,
  input  wire logic [WIDTH-1:0] cmpC,
  input  wire logic [WIDTH-1:0] captureValue,
  input  wire logic [3:0]       waveModeSel,
  input  wire logic             overflowStrobe,
  input  wire logic             captureEvent,
  output logic                  setA,
  output logic                  setB,
  output logic                  setC,
  output logic                  setOvf,
  output logic                  setCap
);
  import timer_irq_pkg::*;

  logic [2:0] matchHeld;
  logic [2:0] next_matchHeld;
  logic       ovfHeld;
  logic       next_ovfHeld;
  logic       topHeld;
  logic       next_topHeld;
  logic       plainMode;
  logic       capIsTop;

  // capture register used as the ceiling
  assign capIsTop = (waveModeSel == MODE_CTC_CAP) || (waveModeSel == MODE_PWM_CAP_A)
                  || (waveModeSel == MODE_PWM_CAP_B) || (waveModeSel == MODE_FAST_CAP);
  assign plainMode = (waveModeSel == MODE_NORMAL) || (waveModeSel == MODE_CTC_CMP_A)
                   || (waveModeSel == MODE_CTC_CAP);

  // sample matches on a tick, report them on the next tick
  always_comb
  begin
    next_matchHeld = matchHeld;
    next_ovfHeld   = ovfHeld;
    next_topHeld   = topHeld;
    if (timerTick)
    begin
      next_matchHeld = {counter == cmpC, counter == cmpB, counter == cmpA};
      next_ovfHeld   = plainMode && counter == COUNT_MAX;
      next_topHeld   = capIsTop && counter == captureValue;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      matchHeld <= 3'h0;
      ovfHeld   <= 1'b0;
      topHeld   <= 1'b0;
    end
    else
    begin
      matchHeld <= next_matchHeld;
      ovfHeld   <= next_ovfHeld;
      topHeld   <= next_topHeld;
    end
  end

  // force strobes never reach here, so forced matches leave flags alone
  assign setA   = timerTick && matchHeld[0];
  assign setB   = timerTick && matchHeld[1];
  assign setC   = timerTick && matchHeld[2];
  // wrap in plain modes, mode-table strobe otherwise
  assign setOvf = timerTick && (plainMode ? ovfHeld : overflowStrobe);
  assign setCap = captureEvent || (timerTick && topHeld);
endmodule : timer_event_detect

// file: dv/timer_irq_flag_bank_asserts.sv
// timer_irq_flag_bank_asserts: port-level checks of the timer flag bank
// assumes: bound into timer_irq_flag_bank, one clock domain
`timescale 1ns/10ps
module timer_irq_flag_bank_asserts
  import timer_irq_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic [7:0]       regAddr,
  input wire logic             regWrite,
  input wire logic [7:0]       regWdata,
  input wire logic [7:0]       regRdata,
  input wire logic             globalIrqEnable,
  input wire logic             irqRequest,
  input wire logic             vectorTaken,
  input wire logic [3:0]       vectorTakenId,
  input wire logic             t1Tick,
  input wire logic [WIDTH-1:0] t1_counter,
  input wire logic [WIDTH-1:0] t1_cmp_b_value,
  input wire logic             t1CaptureEvent,
  input wire logic             t3Tick,
  input wire logic [WIDTH-1:0] t3_counter,
  input wire logic [3:0]       t3_wave_mode_sel,
  input wire logic             t3CapturePinEvent
);
  logic quiet;
  // no set event can land at this edge
  assign quiet = !t1Tick && !t3Tick && !t1CaptureEvent && !t3CapturePinEvent;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // flag and request relations
  // ****************************************
  a_irq_needs_global: assert property (irqRequest |-> globalIrqEnable)
    else $error("request without global enable");
  a_reset_no_irq: assert property ($rose(rst_n) |-> !irqRequest)
    else $error("request right after reset");
  a_t1b_sets: assert property (
    t1Tick && t1_counter == t1_cmp_b_value ##1 t1Tick ##1 regAddr == SHARED_FLAGS_ADDR
    |-> regRdata[S_B]) else $error("timer1 B flag not set");
  a_t3_ovf_sets: assert property (
    t3Tick && t3_counter == COUNT_MAX && t3_wave_mode_sel == MODE_NORMAL ##1 t3Tick
    ##1 regAddr == EXT_FLAGS_ADDR |-> regRdata[E_OVF]) else $error("timer3 overflow lost");
  a_cap_sets: assert property (
    t3CapturePinEvent ##1 regAddr == EXT_FLAGS_ADDR |-> regRdata[E_CAP])
    else $error("timer3 capture flag not set");
  a_w1c_clears: assert property (
    regWrite && regAddr == EXT_FLAGS_ADDR && quiet ##1 regAddr == EXT_FLAGS_ADDR
    |-> (regRdata & $past(regWdata)) == 8'h00) else $error("write one did not clear");
  a_zero_keeps: assert property (
    regWrite && regWdata == 8'h00 && !vectorTaken && regAddr == EXT_FLAGS_ADDR ##1
    regAddr == EXT_FLAGS_ADDR |-> (regRdata & $past(regRdata)) == $past(regRdata))
    else $error("write zero lost a flag");
  a_vector_clears: assert property (
    vectorTaken && vectorTakenId == VEC_T3_CAP && !t3CapturePinEvent && !t3Tick ##1
    regAddr == EXT_FLAGS_ADDR |-> !regRdata[E_CAP]) else $error("vector left flag set");
  a_unused_zero: assert property (
    regAddr == EXT_FLAGS_ADDR || regAddr == SHARED_FLAGS_ADDR |-> regRdata[7:6] == 2'h0
    && (regAddr != SHARED_FLAGS_ADDR || regRdata[1:0] == 2'h0))
    else $error("unused flag bit reads one");
endmodule : timer_irq_flag_bank_asserts
bind timer_irq_flag_bank timer_irq_flag_bank_asserts #(.WIDTH(WIDTH)) asserts_inst (.*);

// file: dv/irq_core_model.sv
// irq_core_model: core side that takes a pending vector after a wait
// assumes: request and vector are combinational from the flag bank
`timescale 1ns/10ps
module irq_core_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       takeOn,
  input  wire logic [3:0] waitCycles,
  input  wire logic       irqRequest,
  input  wire logic [3:0] irqVector,
  output logic            vectorTaken = 1'b0,
  output logic [3:0]      vectorTakenId = 4'h0
);
  logic [3:0] count = 4'h0;
  // count the wait, then pulse the taken vector for one cycle
  always @(posedge ref_clk)
  begin
    vectorTaken <= 1'b0;
    vectorTakenId <= ~vectorTakenId; // id is meaningless outside a pulse
    count <= count + 4'h1;
    if (!rst_n || !takeOn || irqRequest !== 1'b1 || vectorTaken)
      count <= 4'h0;
    else if (count == waitCycles)
    begin
      vectorTaken <= 1'b1;
      vectorTakenId <= irqVector;
    end
  end
endmodule : irq_core_model

// file: dv/tb_timer_irq_flag_bank.sv
// tb_timer_irq_flag_bank: directed scenarios for the timer flag bank
// assumes: package, design, core model and checker compiled before it
`timescale 1ns/10ps
module tb_timer_irq_flag_bank;
  import timer_irq_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, globalIrqEnable = 1'b0;
  logic        t1Tick = 1'b0, t3Tick = 1'b0, t1OverflowStrobe = 1'b0, takeOn = 1'b0;
  logic        t3OverflowStrobe = 1'b0, t1CaptureEvent = 1'b0, t3CapturePinEvent = 1'b0;
  logic        irqRequest, vectorTaken;
  logic [3:0]  irqVector, vectorTakenId, waitCycles = 4'h3;
  logic [3:0]  wave_mode_sel = 4'h0, t3_wave_mode_sel = 4'h0;
  logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [15:0] t1_counter = 16'h0, t1_cmp_a_value = 16'h0, t1_cmp_b_value = 16'h0;
  logic [15:0] t1_cmp_c_value = 16'h0, t1_capture_value = 16'h0, t3_counter = 16'h0;
  logic [15:0] t3_cmp_a_value = 16'h0, t3_cmp_b_value = 16'h0, t3_cmp_c_value = 16'h0;
  logic [15:0] t3_capture_value = 16'h0;
  int          nMismatch = 0, compares = 0;
  timer_irq_flag_bank timer_irq_flag_bank_inst (.*);
  irq_core_model irq_core_model_inst (.*);
  // free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task cyc;
    @(posedge ref_clk);
    #1;
  endtask : cyc
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    cyc;
    regWrite = 1'b0;
    cyc; // idle edge so a following write never re-raises the strobe at once
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    #1;
    check("register", regRdata, exp);
  endtask : rd
  // both timers tick twice, counter first then next
  task ticks(input logic [15:0] first, input logic [15:0] next);
    t1_counter = first;
    t3_counter = first;
    t1Tick = 1'b1;
    t3Tick = 1'b1;
    cyc;
    t1_counter = next;
    t3_counter = next;
    cyc;
    t1Tick = 1'b0;
    t3Tick = 1'b0;
  endtask : ticks
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // scenarios
  // ****************************************
  task test_reset;
    rd(SHARED_FLAGS_ADDR, FLAGS_RESET);
    rd(EXT_FLAGS_ADDR, FLAGS_RESET);
    rd(EXT_MASK_ADDR, MASK_RESET);
    rd(8'h40, 8'h00);
    wr(SHARED_MASK_ADDR, 8'hFF);
    rd(SHARED_MASK_ADDR, SHARED_USED);
    wr(SHARED_MASK_ADDR, 8'h00);
    check("request", irqRequest, 1'b0);
    $display("done test_reset");
  endtask : test_reset
  task test_compare;
    logic [7:0] a;
    logic [7:0] m;
    for (int i = 0; i < 6; i++)
    begin
      {t1_cmp_a_value, t1_cmp_b_value, t1_cmp_c_value} = '0;
      {t3_cmp_a_value, t3_cmp_b_value, t3_cmp_c_value} = '0;
      a = (i == 0 || i == 5) ? SHARED_FLAGS_ADDR : EXT_FLAGS_ADDR;
      case (i)
        0: begin t1_cmp_b_value = 16'h1234; m = 8'h08; end
        1: begin t1_cmp_c_value = 16'h1234; m = 8'h01; end
        2: begin t3_cmp_a_value = 16'h1234; m = 8'h10; end
        3: begin t3_cmp_b_value = 16'h1234; m = 8'h08; end
        4: begin t3_cmp_c_value = 16'h1234; m = 8'h02; end
        default: begin t1_cmp_a_value = 16'h1234; m = 8'h10; end
      endcase
      ticks(16'h1234, 16'h1235);
      rd(a, m);
      wr(a, m);
      rd(a, 8'h00);
    end
    $display("done test_compare");
  endtask : test_compare
  task test_overflow;
    {t1_cmp_a_value, t1_cmp_b_value, t1_cmp_c_value} = {3{16'h5555}};
    {t3_cmp_a_value, t3_cmp_b_value, t3_cmp_c_value} = {3{16'h5555}}; // no match at count zero
    wave_mode_sel = MODE_CTC_CMP_A;
    ticks(COUNT_MAX, 16'h0000);
    rd(SHARED_FLAGS_ADDR, 8'h04);
    rd(EXT_FLAGS_ADDR, 8'h04);
    wr(EXT_FLAGS_ADDR, 8'hFF);
    wr(SHARED_FLAGS_ADDR, 8'hFF);
    t3_wave_mode_sel = MODE_CTC_CAP;
    t3_capture_value = 16'h0100;
    ticks(16'h0100, 16'h0000);
    rd(EXT_FLAGS_ADDR, 8'h20);
    wr(EXT_FLAGS_ADDR, 8'hFF);
    wave_mode_sel = MODE_PWM_CAP_A;
    t3_wave_mode_sel = MODE_FAST_CAP;
    {t1Tick, t3Tick, t1OverflowStrobe, t3OverflowStrobe} = 4'hF;
    cyc;
    {t1Tick, t3Tick, t1OverflowStrobe, t3OverflowStrobe} = 4'h0;
    rd(SHARED_FLAGS_ADDR, 8'h04);
    rd(EXT_FLAGS_ADDR, 8'h04);
    wr(SHARED_FLAGS_ADDR, 8'hFF);
    wr(EXT_FLAGS_ADDR, 8'hFF);
    wave_mode_sel = MODE_NORMAL;
    t3_wave_mode_sel = MODE_NORMAL;
    $display("done test_overflow");
  endtask : test_overflow
  task test_irq;
    int n;
    wr(EXT_MASK_ADDR, 8'h20);
    t3CapturePinEvent = 1'b1;
    t1CaptureEvent = 1'b1;
    cyc;
    t3CapturePinEvent = 1'b0;
    t1CaptureEvent = 1'b0;
    rd(EXT_FLAGS_ADDR, 8'h20);
    rd(SHARED_FLAGS_ADDR, 8'h20);
    check("request", irqRequest, 1'b0);
    globalIrqEnable = 1'b1;
    rd(EXT_FLAGS_ADDR, 8'h20);
    check("request", irqRequest, 1'b1);
    check("vector", irqVector, VEC_T3_CAP);
    takeOn = 1'b1;
    for (n = 0; n < 20 && irqRequest !== 1'b0; n++)
      cyc;
    if (n == 20)
    begin
      nMismatch++;
      report_and_stop;
    end
    rd(EXT_FLAGS_ADDR, 8'h00);
    rd(SHARED_FLAGS_ADDR, 8'h20);
    takeOn = 1'b0;
    globalIrqEnable = 1'b0;
    wr(SHARED_FLAGS_ADDR, 8'h20);
    wr(EXT_MASK_ADDR, 8'h00);
    $display("done test_irq");
  endtask : test_irq
  task test_set_wins;
    t3CapturePinEvent = 1'b1;
    // capture pulse lasts only the write's edge
    fork
      wr(EXT_FLAGS_ADDR, 8'h20);
      begin
        cyc;
        t3CapturePinEvent = 1'b0;
      end
    join
    rd(EXT_FLAGS_ADDR, 8'h20);
    wr(EXT_FLAGS_ADDR, 8'h00);
    rd(EXT_FLAGS_ADDR, 8'h20);
    wr(EXT_FLAGS_ADDR, 8'h20);
    rd(EXT_FLAGS_ADDR, 8'h00);
    $display("done test_set_wins");
  endtask : test_set_wins
  // reset for two cycles, then every scenario in turn
  initial
  begin
    repeat (2) cyc;
    rst_n = 1'b1;
    test_reset;
    test_compare;
    test_overflow;
    test_irq;
    test_set_wins;
    report_and_stop;
  end
endmodule : tb_timer_irq_flag_bank
